// ---- rtl/cp_charge_timer.sv ----
// Purpose: Charge timeout timer counting pump oscillator cycles
// Assumes: Runs on the pump oscillator clock; clear has priority
// Notes:   Terminal count doubles with each step of the time select

`timescale 1ns/100ps

module cp_charge_timer #(
  parameter int unsigned BASE_CYCLES = 1000000
) (
  input  wire logic                       mclk_i,
  input  wire logic                       arst_n_i,
  input  wire logic                       clear_i,
  input  wire logic                       run_i,
  input  wire logic [cp_pkg::TSEL_W-1:0]  tsel_i,
  output logic                            expired_o
);

  logic [cp_pkg::CNT_W-1:0] cnt_r;
  logic [cp_pkg::CNT_W-1:0] cnt_nxt;
  logic [cp_pkg::CNT_W-1:0] term;

  // ********************************************************************
  // Terminal count and count update
  // ********************************************************************
  // Select field shifts the base count: 1x, 2x, 4x, 8x
  always_comb begin
    term    = cp_pkg::CNT_W'(BASE_CYCLES) << tsel_i;
    cnt_nxt = cnt_r;
    if (clear_i) begin
      cnt_nxt = '0;
    end else if (run_i) begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  // Expiry on the last counted cycle so the run lasts exactly term cycles
  assign expired_o = run_i && !clear_i && (cnt_r == term - 1'b1);

  // Count register
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  a_count_bounded: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    run_i |-> (cnt_r < term))
    else $error("charge timer ran past its terminal count");

  a_clear_zero: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    clear_i |=> (cnt_r == '0))
    else $error("charge timer not zeroed on start");

endmodule : cp_charge_timer

// ---- rtl/cp_pkg.sv ----
// Purpose: Shared constants and carriers for the charge pump control block
// Assumes: 8-bit transmitter register port, 4-bit register address
// Notes:   Register reads show reserved bits as zero

package cp_pkg;

  // ********************************************************************
  // Register port geometry
  // ********************************************************************
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // ********************************************************************
  // Register addresses
  // ********************************************************************
  localparam logic [ADDR_W-1:0] ADDR_CTRL_TWO = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_TRIM_DIS = 4'h8;

  // ********************************************************************
  // Field positions in rf_control_two
  // ********************************************************************
  localparam int unsigned BIT_PUMP_RUN     = 0;
  localparam int unsigned BIT_TSEL_LO      = 1;
  localparam int unsigned TSEL_W           = 2;
  localparam int unsigned BIT_SUPPLY_CONN  = 3;
  localparam int unsigned BIT_RESERVE_CONN = 4;

  // ********************************************************************
  // Field positions in rf_trim_discharge
  // ********************************************************************
  localparam int unsigned BIT_DISCHARGE = 5;

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic              RST_BIT  = 1'b0;
  localparam logic [TSEL_W-1:0] RST_TSEL = 2'h0;
  localparam logic [DATA_W-1:0] RST_DATA = 8'h00;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned CNT_W         = 32;
  localparam int unsigned SYNC_STAGES   = 2;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_PUMP = 1'b1
  } pump_state_e;

  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic pump_run;
    logic osc_en;
    logic discharge_en;
    logic reservoir_sw;
    logic supply_sw;
  } pump_ctl_s;

endpackage : cp_pkg

// ---- rtl/cp_pump_ctrl.sv ----
// Purpose: Charge pump run control, timeout and reservoir switch bits
// Assumes: Register strobes come from SPI logic on the same clock
// Notes:   Charge limit sense is asynchronous and is synchronised here
//
// Summary of operation
// - Trim register sits at transmitter address 08; other bits reserved.
// - Discharge bit one turns the reservoir discharge path on.
// - Transmitter reset clears the discharge bit.
// - Pump runs only while the pump run bit is set.
// - Setting pump run powers up the pump oscillator.
// - Timeout timer bounds the charge cycle per time select field.
// - Timeout expiry stops the pump and clears the run bit.
// - Reaching the charge limit stops the pump early.
// - Pump run bit reads back its live state.
// - Software clearing pump run ends the charge cycle at once.
// - Reservoir connect switches amplifier supply onto the reservoir.

`timescale 1ns/100ps

module cp_pump_ctrl #(
  parameter int unsigned TIMEOUT_BASE_CYCLES = 1000000
) (
  input  wire logic                        mclk_i,
  input  wire logic                        arst_n_i,
  input  wire cp_pkg::reg_req_s            reg_req_i,
  input  wire logic [cp_pkg::ADDR_W-1:0]   rd_addr_i,
  output logic      [cp_pkg::DATA_W-1:0]   rd_data_o,
  input  wire logic                        charge_limit_i,
  output cp_pkg::pump_ctl_s                pump_ctl_o
);

  // ********************************************************************
  // Declarations
  // ********************************************************************
  cp_pkg::pump_state_e            state_r;
  cp_pkg::pump_state_e            state_nxt;
  logic [cp_pkg::TSEL_W-1:0]      tsel_r;
  logic [cp_pkg::TSEL_W-1:0]      tsel_nxt;
  logic                           supply_r;
  logic                           supply_nxt;
  logic                           reserve_r;
  logic                           reserve_nxt;
  logic                           discharge_r;
  logic                           discharge_nxt;
  logic [cp_pkg::DATA_W-1:0]      rd_data_nxt;
  logic [cp_pkg::SYNC_STAGES-1:0] limit_sync_r;
  logic                           limit_s;
  logic                           wr_ctrl;
  logic                           wr_trim;
  logic                           start;
  logic                           pump_run;
  logic                           expired;

  // Address decode, used for writes and reads alike
  function automatic logic hit(input logic [cp_pkg::ADDR_W-1:0] a,
                               input logic [cp_pkg::ADDR_W-1:0] r);
    hit = (a == r);
  endfunction : hit

  assign wr_ctrl  = reg_req_i.wr && hit(reg_req_i.addr, cp_pkg::ADDR_CTRL_TWO);
  assign wr_trim  = reg_req_i.wr && hit(reg_req_i.addr, cp_pkg::ADDR_TRIM_DIS);
  assign start    = wr_ctrl && reg_req_i.wdata[cp_pkg::BIT_PUMP_RUN];
  assign pump_run = (state_r == cp_pkg::ST_PUMP);
  assign limit_s  = limit_sync_r[cp_pkg::SYNC_STAGES-1];

  // ********************************************************************
  // Charge limit synchroniser
  // ********************************************************************
  // Only the last stage is read; the first may be metastable
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      limit_sync_r <= '0;
    end else begin
      limit_sync_r <= {limit_sync_r[cp_pkg::SYNC_STAGES-2:0],
                       charge_limit_i};
    end
  end

  // ********************************************************************
  // Timeout timer
  // ********************************************************************
  cp_charge_timer #(
    .BASE_CYCLES (TIMEOUT_BASE_CYCLES)
  ) u_timer (
    .mclk_i    (mclk_i),
    .arst_n_i  (arst_n_i),
    .clear_i   (start),
    .run_i     (pump_run),
    .tsel_i    (tsel_r),
    .expired_o (expired)
  );

  // ********************************************************************
  // Pump state and control bits
  // ********************************************************************
  // A software write in the same cycle as a hardware stop wins, so a
  // restart issued right at expiry is not swallowed
  always_comb begin
    state_nxt     = state_r;
    tsel_nxt      = tsel_r;
    supply_nxt    = supply_r;
    reserve_nxt   = reserve_r;
    discharge_nxt = discharge_r;
    case (state_r)
      cp_pkg::ST_IDLE: begin
        if (start) begin
          state_nxt = cp_pkg::ST_PUMP;
        end
      end
      cp_pkg::ST_PUMP: begin
        if (expired || limit_s) begin
          state_nxt = cp_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = cp_pkg::ST_IDLE;
      end
    endcase
    if (wr_ctrl) begin
      // Clearing the run bit stops the cycle at once
      state_nxt   = reg_req_i.wdata[cp_pkg::BIT_PUMP_RUN] ?
                    cp_pkg::ST_PUMP : cp_pkg::ST_IDLE;
      tsel_nxt    = reg_req_i.wdata[cp_pkg::BIT_TSEL_LO +: cp_pkg::TSEL_W];
      supply_nxt  = reg_req_i.wdata[cp_pkg::BIT_SUPPLY_CONN];
      reserve_nxt = reg_req_i.wdata[cp_pkg::BIT_RESERVE_CONN];
    end
    if (wr_trim) begin
      discharge_nxt = reg_req_i.wdata[cp_pkg::BIT_DISCHARGE];
    end
  end

  // Control registers; reset leaves every path off
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r     <= cp_pkg::ST_IDLE;
      tsel_r      <= cp_pkg::RST_TSEL;
      supply_r    <= cp_pkg::RST_BIT;
      reserve_r   <= cp_pkg::RST_BIT;
      discharge_r <= cp_pkg::RST_BIT;
    end else begin
      state_r     <= state_nxt;
      tsel_r      <= tsel_nxt;
      supply_r    <= supply_nxt;
      reserve_r   <= reserve_nxt;
      discharge_r <= discharge_nxt;
    end
  end

  // ********************************************************************
  // Read back
  // ********************************************************************
  // Run bit shows the live state, so software can poll for the end
  always_comb begin
    rd_data_nxt = cp_pkg::RST_DATA;
    if (hit(rd_addr_i, cp_pkg::ADDR_CTRL_TWO)) begin
      rd_data_nxt[cp_pkg::BIT_PUMP_RUN]     = pump_run;
      rd_data_nxt[cp_pkg::BIT_TSEL_LO +: cp_pkg::TSEL_W] = tsel_r;
      rd_data_nxt[cp_pkg::BIT_SUPPLY_CONN]  = supply_r;
      rd_data_nxt[cp_pkg::BIT_RESERVE_CONN] = reserve_r;
    end else if (hit(rd_addr_i, cp_pkg::ADDR_TRIM_DIS)) begin
      rd_data_nxt[cp_pkg::BIT_DISCHARGE]    = discharge_r;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_data_o <= cp_pkg::RST_DATA;
    end else begin
      rd_data_o <= rd_data_nxt;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  // Oscillator follows the run bit; the pump switches only while it runs
  always_comb begin
    pump_ctl_o.pump_run     = pump_run;
    pump_ctl_o.osc_en       = pump_run;
    pump_ctl_o.discharge_en = discharge_r;
    pump_ctl_o.reservoir_sw = reserve_r;
    pump_ctl_o.supply_sw    = supply_r;
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  a_trim_write: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    wr_trim |=> pump_ctl_o.discharge_en ==
                $past(reg_req_i.wdata[cp_pkg::BIT_DISCHARGE]))
    else $error("discharge path does not follow trim write");

  a_trim_hold: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    !wr_trim |=> $stable(pump_ctl_o.discharge_en))
    else $error("discharge path changed without trim write");

  a_pump_start: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    !pump_run && !start |=> !pump_ctl_o.pump_run)
    else $error("pump started without a run write");

  a_osc_follows: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    start |=> pump_ctl_o.osc_en && pump_ctl_o.pump_run)
    else $error("oscillator not enabled on pump start");

  a_timeout_stop: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    expired && !wr_ctrl |=> !pump_ctl_o.pump_run && !pump_ctl_o.osc_en)
    else $error("pump still running after timeout");

  a_limit_stop: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    $past(charge_limit_i, 2) && pump_run && !wr_ctrl |=> !pump_run)
    else $error("pump still running past charge limit");

  a_sw_stop: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    wr_ctrl && !reg_req_i.wdata[cp_pkg::BIT_PUMP_RUN] |=> !pump_run)
    else $error("software clear did not stop the pump");

  a_read_live: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    hit(rd_addr_i, cp_pkg::ADDR_CTRL_TWO) |=>
      rd_data_o[cp_pkg::BIT_PUMP_RUN] == $past(pump_run))
    else $error("run bit read back is not the live state");

  a_limit_sync: assert property (
    @(posedge mclk_i) disable iff (!arst_n_i)
    ##2 limit_s == $past(charge_limit_i, 2))
    else $error("charge limit not delayed by two stages");

endmodule : cp_pump_ctrl

// ---- verif/cp_ctrl_model.sv ----
// Purpose: Controller model on the pump block register port
// Assumes: Drives after the falling edge, block samples on rising
// Notes:   Released write data shows the inverse of the last value
`timescale 1ns/100ps
module cp_ctrl_model (
  input  wire logic                      mclk_i,
  input  wire logic [cp_pkg::DATA_W-1:0] rd_data_i,
  output cp_pkg::reg_req_s               reg_req_o,
  output logic      [cp_pkg::ADDR_W-1:0] rd_addr_o,
  output logic                           limit_o
);
  // ****************************************************************
  // Register port and sense driver
  // ****************************************************************
  // Quiet bus at time zero
  initial begin
    reg_req_o = '0;
    rd_addr_o = '0;
    limit_o   = 1'b0;
  end
  // One write, held across exactly one rising edge
  task automatic write_reg(input logic [cp_pkg::ADDR_W-1:0] a,
                           input logic [cp_pkg::DATA_W-1:0] d);
    @(negedge mclk_i);
    reg_req_o = '{wr: 1'b1, addr: a, wdata: d};
    @(negedge mclk_i);
    reg_req_o.wr    = 1'b0;
    reg_req_o.wdata = ~d; // Stale data must not look valid
  endtask : write_reg
  // Read data lands one edge after the address
  task automatic read_reg(input  logic [cp_pkg::ADDR_W-1:0] a,
                          output logic [cp_pkg::DATA_W-1:0] d);
    @(negedge mclk_i);
    rd_addr_o = a;
    @(negedge mclk_i);
    d = rd_data_i;
  endtask : read_reg
  // Start charging with both connect bits clear
  task automatic start_charge(input logic [1:0] tsel);
    write_reg(cp_pkg::ADDR_CTRL_TWO, {5'h00, tsel, 1'b1});
  endtask : start_charge
  // Reservoir voltage sense level
  task automatic set_limit(input logic v);
    @(negedge mclk_i);
    limit_o = v;
  endtask : set_limit
endmodule : cp_ctrl_model

// ---- verif/rf_charge_pump_control_tb.sv ----
// Purpose: Self-checking bench for the charge pump control block
// Assumes: Timeout base shortened to 8 oscillator cycles
// Notes:   All register and sense stimulus goes through the controller model; reset is driven here
`timescale 1ns/100ps
module rf_charge_pump_control_tb;
  // ****************************************************************
  // Harness
  // ****************************************************************
  localparam int unsigned BASE = 8;
  logic                      mclk_i;
  logic                      arst_n_i;
  cp_pkg::reg_req_s          reg_req;
  logic [cp_pkg::ADDR_W-1:0] rd_addr;
  logic [cp_pkg::DATA_W-1:0] rd_data;
  logic                      limit;
  cp_pkg::pump_ctl_s         ctl;
  logic [cp_pkg::DATA_W-1:0] d;
  int                        fails;
  int                        compares;
  int                        n;

  cp_pump_ctrl #(.TIMEOUT_BASE_CYCLES(BASE)) cp_pump_ctrl_inst (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .reg_req_i(reg_req),
    .rd_addr_i(rd_addr), .rd_data_o(rd_data),
    .charge_limit_i(limit), .pump_ctl_o(ctl));
  cp_ctrl_model cp_ctrl_model_inst (
    .mclk_i(mclk_i), .rd_data_i(rd_data), .reg_req_o(reg_req),
    .rd_addr_o(rd_addr), .limit_o(limit));

  // Free running pump oscillator
  always #12.5 mclk_i = ~mclk_i;

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  // Count cycles the pump stays on, bounded
  task automatic count_run();
    n = 0;
    while (ctl.pump_run === 1'b1 && n < 200) begin
      n++;
      @(negedge mclk_i);
    end
  endtask : count_run

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset_vals();
    check("ctl after reset", 32'(ctl), 32'h0);
    cp_ctrl_model_inst.read_reg(cp_pkg::ADDR_TRIM_DIS, d);
    check("trim after reset", 32'(d), 32'h0);
  endtask : t_reset_vals

  // Every time select, run to timeout
  task automatic t_timeout();
    for (int t = 0; t < 4; t++) begin
      cp_ctrl_model_inst.start_charge(2'(t));
      count_run();
      check("timeout length", 32'(n), 32'(BASE << t));
      check("osc off", 32'(ctl.osc_en), 32'h0);
      cp_ctrl_model_inst.read_reg(cp_pkg::ADDR_CTRL_TWO, d);
      check("run bit cleared", 32'(d), 32'(t << 1));
    end
  endtask : t_timeout

  // Limit sense ends the cycle after the synchroniser
  task automatic t_limit();
    cp_ctrl_model_inst.start_charge(2'h3);
    cp_ctrl_model_inst.read_reg(cp_pkg::ADDR_CTRL_TWO, d);
    check("live run bit", 32'(d), 32'h07);
    check("osc on", 32'(ctl.osc_en), 32'h1);
    cp_ctrl_model_inst.set_limit(1'b1);
    repeat (2) @(negedge mclk_i);
    check("run during sync", 32'(ctl.pump_run), 32'h1);
    @(negedge mclk_i);
    check("limit stop", 32'(ctl.pump_run), 32'h0);
    cp_ctrl_model_inst.set_limit(1'b0);
  endtask : t_limit

  // Restart zeroes the timer; software clear stops at once
  task automatic t_sw_stop();
    cp_ctrl_model_inst.start_charge(2'h0);
    repeat (3) @(negedge mclk_i);
    cp_ctrl_model_inst.start_charge(2'h0);
    count_run();
    check("restart length", 32'(n), 32'(BASE));
    cp_ctrl_model_inst.start_charge(2'h2);
    cp_ctrl_model_inst.write_reg(cp_pkg::ADDR_CTRL_TWO, 8'h00);
    check("sw stop run", 32'(ctl.pump_run), 32'h0);
    check("sw stop osc", 32'(ctl.osc_en), 32'h0);
  endtask : t_sw_stop

  // Discharge bit, reserved bits, unmapped place, reset clear
  task automatic t_discharge();
    cp_ctrl_model_inst.write_reg(cp_pkg::ADDR_CTRL_TWO, 8'h10);
    cp_ctrl_model_inst.write_reg(cp_pkg::ADDR_TRIM_DIS, 8'hFF);
    check("discharge on", 32'(ctl.discharge_en), 32'h1);
    cp_ctrl_model_inst.read_reg(cp_pkg::ADDR_TRIM_DIS, d);
    check("trim readback", 32'(d), 32'h20);
    cp_ctrl_model_inst.write_reg(4'h9, 8'h00);
    cp_ctrl_model_inst.read_reg(4'h9, d);
    check("unmapped read", 32'(d), 32'h0);
    check("discharge kept", 32'(ctl.discharge_en), 32'h1);
    @(negedge mclk_i);
    arst_n_i = 1'b0;
    #1;
    check("reset clears", 32'(ctl), 32'h0);
    repeat (2) @(negedge mclk_i);
    arst_n_i = 1'b1;
    // Set first, so that the clearing write has something to undo
    cp_ctrl_model_inst.write_reg(cp_pkg::ADDR_TRIM_DIS, 8'h20);
    check("discharge again", 32'(ctl.discharge_en), 32'h1);
    cp_ctrl_model_inst.write_reg(cp_pkg::ADDR_TRIM_DIS, 8'h00);
    check("discharge off", 32'(ctl.discharge_en), 32'h0);
  endtask : t_discharge

  // Connect bits steer the amplifier supply, one at a time
  task automatic t_switches();
    cp_ctrl_model_inst.write_reg(cp_pkg::ADDR_CTRL_TWO, 8'h10);
    check("reservoir sw", 32'(ctl[1:0]), 32'h2);
    cp_ctrl_model_inst.write_reg(cp_pkg::ADDR_CTRL_TWO, 8'h00);
    cp_ctrl_model_inst.write_reg(cp_pkg::ADDR_CTRL_TWO, 8'h08);
    check("supply sw", 32'(ctl[1:0]), 32'h1);
  endtask : t_switches

  // Main sequence
  initial begin
    mclk_i   = 1'b0;
    arst_n_i = 1'b0;
    fails    = 0;
    compares = 0;
    repeat (5) @(negedge mclk_i);
    arst_n_i = 1'b1;
    t_reset_vals();
    t_timeout();
    t_limit();
    t_sw_stop();
    t_discharge();
    t_switches();
    conclude();
  end

  // Watchdog, far beyond the expected few hundred cycles
  initial begin
    #500000;
    fails++;
    conclude();
  end
endmodule : rf_charge_pump_control_tb
